/* File: design/sscd_pkg.sv */
// Purpose: Shared constants and types for the SPI switch-control target.
// Assumes: One 8-bit register map; frames of 16 bits, 24 bits with CRC.
// Notes:   All offsets, keys, lengths and reset values live here.
package sscd_pkg;
  // Register addresses (7-bit).
  localparam logic [6:0] A_SW    = 7'h01;
  localparam logic [6:0] A_CFG   = 7'h02;
  localparam logic [6:0] A_FLG   = 7'h03;
  localparam logic [6:0] A_BURST = 7'h05;
  localparam logic [6:0] A_SRST  = 7'h0B;
  // Fixed bytes of the protocol.
  localparam logic [7:0] ALIGN    = 8'h25;
  localparam logic [7:0] CLR_CMD  = 8'h6C;
  localparam logic [7:0] CLR_DATA = 8'hA9;
  localparam logic [7:0] SR_KEY1  = 8'hA3;
  localparam logic [7:0] SR_KEY2  = 8'h05;
  localparam logic [7:0] DC_CMD   = 8'h25;
  localparam logic [7:0] DC_DATA  = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  // Bit positions counted in rising SCLK edges.
  localparam logic [4:0] LEN_PLAIN = 5'h10;
  localparam logic [4:0] LEN_CRC   = 5'h18;
  localparam logic [4:0] POS_ADDR  = 5'h08;
  localparam logic [4:0] POS_INV   = 5'h09;
  localparam logic [4:0] POS_MAX   = 5'h1F;
  // Field positions in the flag and configuration fields.
  localparam int F_CRC  = 0;
  localparam int F_SCLK = 1;
  localparam int F_RW   = 2;
  // Register contents carried together.
  typedef struct packed {
    logic [3:0] sw;     // Switch enables.
    logic [2:0] cfg;    // Error check enables.
    logic [2:0] flags;  // Sticky error flags.
    logic       burst;  // Burst mode enable.
  } sscd_regs_s;
  localparam sscd_regs_s REGS_RST = '{sw: 4'h0, cfg: 3'h6, flags: 3'h0, burst: 1'h0};
  // Interface modes.
  typedef enum logic {MODE_ADDR, MODE_DAISY} sscd_mode_e;
endpackage

/* File: design/sscd_top.sv */
// Purpose: SPI target for a quad switch: framing, CRC, error checks, burst, daisy chain.
// Assumes: MCLK far faster than SCLK; SPI mode 0 timing; pins resynchronised here.
// Notes:   SDO is open drain; the host must pull it up.
// How it works
// - CRC mode adds eight clocks, 24 total.
// - CRC covers R/W, address and data.
// - CRC polynomial 0x07, seed zero.
// - CRC mode writes at the 24th edge.
// - Bad CRC blocks write, sets CRC flag.
// - In CRC mode host sends CRC on every frame; device on every reply.
// - CRC check off after reset, configurable.
// - Wrong clock count sets SCLK flag.
// - Short frames never write.
// - Long frames write at 16, or at 24 with CRC, flag error.
// - Bad address or read-only write flagged.
// - Address checked at ninth edge; blocks write.
// - Frame 0x6CA9 clears all error flags.
// - Burst takes back-to-back commands, aligned replies.
// - Burst total must be multiple of length.
// - Writes 0xA3 then 0x05 to 0x0B reset.
// - Command 0x2500 enters daisy chain permanently.
// - Daisy SDO is SDI delayed eight clocks.
// - Chip select rise loads last byte's low nibble into switches.
// - Frame is R/W, 7-bit address, 8 data.
// - First bit zero writes, one reads.
// - Alignment byte 0x25 leads every reply in address mode.
`timescale 1ns/10ps
module sscd_top
(
  // Clock and reset.
  input  wire logic       MCLK,
  input  wire logic       RST,
  // SPI pins.
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       SDI,
  output logic            SDO_OUT,
  output logic            SDO_OE_N,
  // Status.
  output logic [3:0]      SW_EN,
  output logic [2:0]      ERR_FLAGS,
  output logic [2:0]      ERR_CFG,
  output logic            BURST_ON,
  output logic            DAISY_ON
);
  // Two-stage synchronisers plus an edge history stage.
  logic [2:0] cs_ff, sck_ff;   // Bit 0 feeds only bit 1.
  logic [1:0] sdi_ff;          // Bit 0 feeds only bit 1.
  // Protocol state.
  sscd_pkg::sscd_regs_s reg_ff, nxt_reg;   // Register map.
  sscd_pkg::sscd_mode_e mode_ff, nxt_mode; // Address or daisy mode.
  logic [4:0]  pos_ff, nxt_pos;            // Rising edges in this command.
  logic [23:0] rx_ff, nxt_rx;              // Received bits.
  logic [23:0] tx_ff, nxt_tx;              // Reply bits for this command.
  logic [7:0]  cmd_ff, nxt_cmd;            // R/W and address byte.
  logic [7:0]  dsh_ff, nxt_dsh;            // Daisy delay line.
  logic        inv_ff, nxt_inv;            // Command flagged invalid.
  logic        arm_ff, nxt_arm;            // First reset key seen.
  logic        oe_n_ff, nxt_oe_n;          // SDO release, low drives.
  // Edge events, decoded from the second and third stages.
  logic cs_fall, cs_rise, sck_rise, sck_fall, sdi_s, cs_low;
  logic [4:0]  len, pos1;
  logic [15:0] pay;
  logic [7:0]  rdata;
  logic        wr_evt, crc_ok, crc_bad;

  assign cs_fall  = cs_ff[2] & ~cs_ff[1];
  assign cs_rise  = ~cs_ff[2] & cs_ff[1];
  assign cs_low   = ~cs_ff[1];
  assign sck_rise = sck_ff[1] & ~sck_ff[2];
  assign sck_fall = ~sck_ff[1] & sck_ff[2];
  assign sdi_s    = sdi_ff[1];

  // Bitwise CRC-8, MSB first; the zero seed lets a quiet line give zero.
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = sscd_pkg::CRC_SEED;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ sscd_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // True when a command byte names no register or writes the flag register.
  function automatic logic addr_bad(input logic [7:0] c);
    logic b;
    b = 1'b1;
    if (c == sscd_pkg::CLR_CMD || c == sscd_pkg::DC_CMD)
    begin
      b = 1'b0; // The clear and daisy commands are exempt.
    end
    else if (c[6:0] == sscd_pkg::A_FLG)
    begin
      b = ~c[7];
    end
    else if (c[6:0] == sscd_pkg::A_SW || c[6:0] == sscd_pkg::A_CFG ||
             c[6:0] == sscd_pkg::A_BURST || c[6:0] == sscd_pkg::A_SRST)
    begin
      b = 1'b0;
    end
    return b;
  endfunction

  // Pin synchronisers; reset loads CS_N high, SCLK and SDI low.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      cs_ff  <= 3'h7;
      sck_ff <= 3'h0;
      sdi_ff <= 2'h0;
    end
    else
    begin
      cs_ff  <= {cs_ff[1:0], CS_N};
      sck_ff <= {sck_ff[1:0], SCLK};
      sdi_ff <= {sdi_ff[0], SDI};
    end
  end

  // Frame length, next position and the payload as it stands after this edge.
  assign len    = reg_ff.cfg[sscd_pkg::F_CRC] ? sscd_pkg::LEN_CRC : sscd_pkg::LEN_PLAIN;
  assign pos1   = (pos_ff == sscd_pkg::POS_MAX) ? pos_ff : pos_ff + 5'h01;
  assign nxt_rx = sck_rise && cs_low ? {rx_ff[22:0], sdi_s} : rx_ff;
  assign pay    = reg_ff.cfg[sscd_pkg::F_CRC] ? nxt_rx[23:8] : nxt_rx[15:0];
  assign crc_ok = ~reg_ff.cfg[sscd_pkg::F_CRC] || (crc8(pay) == nxt_rx[7:0]);
  // The command completes on the length-th edge; later edges write only in burst mode.
  assign wr_evt = sck_rise && cs_low && mode_ff == sscd_pkg::MODE_ADDR &&
                  pos1 == len && pos_ff != sscd_pkg::POS_MAX;
  assign crc_bad = wr_evt && ~crc_ok;

  // Read mux over the register map; reserved bits read zero.
  always_comb
  begin
    rdata = 8'h00;
    unique case (nxt_rx[6:0])
      sscd_pkg::A_SW:    rdata = {4'h0, reg_ff.sw};
      sscd_pkg::A_CFG:   rdata = {5'h00, reg_ff.cfg};
      sscd_pkg::A_FLG:   rdata = {5'h00, reg_ff.flags};
      sscd_pkg::A_BURST: rdata = {7'h00, reg_ff.burst};
      default:           rdata = 8'h00;
    endcase
  end

  // Next-state logic for the whole protocol engine.
  always_comb
  begin
    nxt_reg  = reg_ff;
    nxt_mode = mode_ff;
    nxt_pos  = pos_ff;
    nxt_tx   = tx_ff;
    nxt_cmd  = cmd_ff;
    nxt_dsh  = dsh_ff;
    nxt_inv  = inv_ff;
    nxt_arm  = arm_ff;
    nxt_oe_n = oe_n_ff;
    if (cs_fall)
    begin
      // A new frame starts; the first alignment bit, or in daisy mode the first delayed bit, is out before the first edge.
      nxt_pos  = 5'h00;
      nxt_inv  = 1'b0;
      nxt_tx   = {sscd_pkg::ALIGN, 16'h0000};
      nxt_oe_n = (mode_ff == sscd_pkg::MODE_DAISY) ? dsh_ff[7] : sscd_pkg::ALIGN[7];
    end
    else if (cs_rise)
    begin
      nxt_oe_n = 1'b1;
      if (mode_ff == sscd_pkg::MODE_DAISY)
      begin
        nxt_reg.sw = dsh_ff[3:0];
      end
      else if (reg_ff.cfg[sscd_pkg::F_SCLK] && pos_ff != 5'h00 &&
               (reg_ff.burst || pos_ff != len))
      begin
        // A counter left off zero in burst mode, or off both zero and the frame length otherwise, means a wrong clock count.
        nxt_reg.flags[sscd_pkg::F_SCLK] = 1'b1;
      end
    end
    else if (sck_rise && cs_low)
    begin
      nxt_pos = pos1;
      if (mode_ff == sscd_pkg::MODE_DAISY)
      begin
        nxt_dsh = {dsh_ff[6:0], sdi_s};
      end
      else if (pos1 == sscd_pkg::POS_ADDR)
      begin
        // Address known: reply data and its CRC go into the second and third bytes.
        nxt_cmd = nxt_rx[7:0];
        nxt_tx[15:0] = nxt_rx[7] ? {rdata, crc8({sscd_pkg::ALIGN, rdata})}
                                 : {8'h00, crc8({sscd_pkg::ALIGN, 8'h00})};
      end
      else if (pos1 == sscd_pkg::POS_INV && reg_ff.cfg[sscd_pkg::F_RW] && addr_bad(cmd_ff))
      begin
        nxt_inv = 1'b1;
        nxt_reg.flags[sscd_pkg::F_RW] = 1'b1;
      end
      if (wr_evt)
      begin
        nxt_arm = 1'b0;
        if (reg_ff.burst)
        begin
          // Restart the command counter so the next reply stays aligned.
          nxt_pos = 5'h00;
          nxt_inv = 1'b0;
          nxt_tx  = {sscd_pkg::ALIGN, 16'h0000};
        end
        if (!crc_ok)
        begin
          nxt_reg.flags[sscd_pkg::F_CRC] = 1'b1;
        end
        else if (!cmd_ff[7] && !inv_ff)
        begin
          if (pay == {sscd_pkg::CLR_CMD, sscd_pkg::CLR_DATA})
          begin
            nxt_reg.flags = 3'h0;
          end
          else if (pay == {sscd_pkg::DC_CMD, sscd_pkg::DC_DATA})
          begin
            nxt_mode = sscd_pkg::MODE_DAISY;
            nxt_dsh  = 8'h00;
          end
          else
          begin
            unique case (cmd_ff[6:0])
              sscd_pkg::A_SW:    nxt_reg.sw = pay[3:0];
              sscd_pkg::A_CFG:   nxt_reg.cfg = pay[2:0];
              sscd_pkg::A_BURST: nxt_reg.burst = pay[0];
              sscd_pkg::A_SRST:
              begin
                if (arm_ff && pay[7:0] == sscd_pkg::SR_KEY2)
                begin
                  nxt_reg = sscd_pkg::REGS_RST;
                end
                nxt_arm = (pay[7:0] == sscd_pkg::SR_KEY1);
              end
              default:           nxt_reg = reg_ff;
            endcase
          end
        end
      end
    end
    else if (sck_fall && cs_low)
    begin
      // Bits past the reply release the line, reading as one.
      if (mode_ff == sscd_pkg::MODE_DAISY)
      begin
        nxt_oe_n = dsh_ff[7];
      end
      else
      begin
        nxt_oe_n = (pos_ff < sscd_pkg::LEN_CRC) ? tx_ff[5'h17 - pos_ff] : 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      reg_ff  <= sscd_pkg::REGS_RST;
      mode_ff <= sscd_pkg::MODE_ADDR;
      pos_ff  <= 5'h00;
      rx_ff   <= 24'h000000;
      tx_ff   <= 24'h000000;
      cmd_ff  <= 8'h00;
      dsh_ff  <= 8'h00;
      inv_ff  <= 1'b0;
      arm_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      reg_ff  <= nxt_reg;
      mode_ff <= nxt_mode;
      pos_ff  <= nxt_pos;
      rx_ff   <= nxt_rx;
      tx_ff   <= nxt_tx;
      cmd_ff  <= nxt_cmd;
      dsh_ff  <= nxt_dsh;
      inv_ff  <= nxt_inv;
      arm_ff  <= nxt_arm;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // Outputs straight from flip-flops; SDO only ever pulls low.
  assign SDO_OUT   = 1'b0;
  assign SDO_OE_N  = oe_n_ff;
  assign SW_EN     = reg_ff.sw;
  assign ERR_FLAGS = reg_ff.flags;
  assign ERR_CFG   = reg_ff.cfg;
  assign BURST_ON  = reg_ff.burst;
  assign DAISY_ON  = (mode_ff == sscd_pkg::MODE_DAISY);

  // Checks on the engine's own behaviour.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sdo_release_a: assert property (cs_rise |=> SDO_OE_N ##1 (SDO_OE_N || cs_low))
    else $error("SDO not released after chip select rise");
  align_lead_a: assert property (cs_fall && !DAISY_ON |=> !SDO_OE_N)
    else $error("first alignment bit not driven low");
  crc_flag_a: assert property (crc_bad |=> ERR_FLAGS[0])
    else $error("CRC mismatch did not set flag");
  crc_nowrite_a: assert property (crc_bad |=> $stable(SW_EN) && $stable(ERR_CFG))
    else $error("write happened despite CRC mismatch");
  reg_cause_a: assert property (!DAISY_ON && ($changed(SW_EN) || $changed(ERR_CFG))
                                |-> $past(wr_evt))
    else $error("register changed without a complete command");
  inv_block_a: assert property (wr_evt && inv_ff |=> $stable(SW_EN) && $stable(BURST_ON))
    else $error("invalid command wrote a register");
  sclk_flag_a: assert property (cs_rise && !DAISY_ON && ERR_CFG[1] && !BURST_ON &&
                                pos_ff != 5'h00 && pos_ff != len |=> ERR_FLAGS[1])
    else $error("clock count error not flagged");
  flag_sticky_a: assert property ($fell(ERR_FLAGS[0]) |-> $past(wr_evt))
    else $error("error flag dropped without clear");
  daisy_hold_a: assert property (DAISY_ON |=> DAISY_ON [*8])
    else $error("left daisy chain mode without reset");

  write_c: cover property (wr_evt && crc_ok && !cmd_ff[7]);
  daisy_c: cover property ($rose(DAISY_ON));
  crcerr_c: cover property ($rose(ERR_FLAGS[0]));
endmodule // sscd_top

/* File: tb/sscd_host.sv */
// Purpose: Host model that drives SPI mode 0 frames into the target.
// Assumes: SCLK period of 16 MCLK cycles; SDO is pulled up by the bench.
// Notes:   SDI flips after each frame, so a stale bit is never mistaken for data.
`timescale 1ns/10ps
module sscd_host
(
  // System clock.
  input  wire logic mclk,
  // SPI lines.
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  // Idle state: deselected, clock low, as mode 0 wants.
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    sdi  = 1'h0;
  end
  // Sends n bits MSB first from tx[47]; reply bits gather at the LSB end of rx.
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    @(posedge mclk);
    cs_n <= 1'h0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      sclk <= 1'h0;
      sdi  <= tx[47 - i];
      repeat (8) @(posedge mclk);
      sclk <= 1'h1;
      rx = {rx[46:0], sdo};
      repeat (7) @(posedge mclk);
    end
    @(posedge mclk);
    sclk <= 1'h0;
    repeat (8) @(posedge mclk);
    cs_n <= 1'h1;
    sdi  <= ~sdi;
    repeat (8) @(posedge mclk);
  endtask
endmodule // sscd_host

/* File: tb/sscd_top_bench.sv */
// Purpose: Self-checking bench for the SPI switch target.
// Assumes: Host model sscd_host; SDO pull-up modelled here.
// Notes:   Status word {sw, flags, cfg, burst, daisy} is compared whole.
`timescale 1ns/10ps
module sscd_top_bench;
  logic        mclk;       // System clock.
  logic        rst;        // Reset, active high.
  logic        cs_n;       // Chip select.
  logic        sclk;       // SPI clock.
  logic        sdi;        // Host data.
  logic        sdo_out;    // Open-drain value.
  logic        sdo_oe_n;   // Pull-down enable.
  logic [3:0]  sw_en;      // Switch enables.
  logic [2:0]  err_flags;  // Sticky flags.
  logic [2:0]  err_cfg;    // Check enables.
  logic        burst_on;   // Burst mode.
  logic        daisy_on;   // Daisy mode.
  logic [47:0] rx;         // Last reply.
  logic [11:0] exp_st;     // Expected status word.
  logic [7:0]  d;          // Random data.
  logic [15:0] b;          // Daisy frame.
  logic [7:0]  last;       // Daisy shift contents.
  int          mismatches; // Failed compares.
  int          n_checks;   // All compares.
  int          seed;       // Random seed.
  // Read-only, missing for write, missing for read.
  logic [7:0]  bad [3] = '{8'h03, 8'h7F, 8'hFF};
  // The pull-up wins whenever the target lets go.
  wire         sdo = sdo_oe_n ? 1'h1 : sdo_out;
  // Free-running 100 MHz clock.
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  sscd_top dut
  (
    .MCLK      (mclk),
    .RST       (rst),
    .CS_N      (cs_n),
    .SCLK      (sclk),
    .SDI       (sdi),
    .SDO_OUT   (sdo_out),
    .SDO_OE_N  (sdo_oe_n),
    .SW_EN     (sw_en),
    .ERR_FLAGS (err_flags),
    .ERR_CFG   (err_cfg),
    .BURST_ON  (burst_on),
    .DAISY_ON  (daisy_on)
  );
  sscd_host host
  (
    .mclk (mclk),
    .cs_n (cs_n),
    .sclk (sclk),
    .sdi  (sdi),
    .sdo  (sdo)
  );
  // CRC-8, polynomial 0x07, seed zero, MSB first.
  function automatic logic [7:0] crc8(input logic [15:0] p);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ p[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // One command with its CRC byte behind it; short frames simply stop early.
  function automatic logic [47:0] fr(input logic [15:0] p);
    return {p, crc8(p), 24'h000000};
  endfunction
  task automatic send(input logic [15:0] p, input int n);
    host.xfer(fr(p), n, rx);
  endtask
  task automatic chk_st();
    n_checks++;
    if ({sw_en, err_flags, err_cfg, burst_on, daisy_on} !== exp_st)
    begin
      mismatches++;
      $display("[ERR] %0t status %h exp %h", $time,
               {sw_en, err_flags, err_cfg, burst_on, daisy_on}, exp_st);
    end
  endtask
  task automatic chk_rx(input logic [47:0] e);
    n_checks++;
    if (rx !== e)
    begin
      mismatches++;
      $display("[ERR] %0t reply %h exp %h", $time, rx, e);
    end
  endtask
  // Hardware reset, then the start-up wait before any command.
  task automatic hw_reset();
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    exp_st = 12'h018;
    @(posedge mclk);
    chk_st();
    repeat (12000) @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    $display("[ERR] %0t run too long", $time);
    finish_test();
  end
  initial
  begin
    seed = 32'h1a83a366;
    mismatches = 0;
    n_checks = 0;
    hw_reset();
    for (int k = 0; k < 4; k++)
    begin
      d = $random(seed);
      send({8'h01, d}, 16);
      chk_rx(48'h2500);
      exp_st[11:8] = d[3:0];
      chk_st();
      send(16'h8100, 16);
      chk_rx({32'h0, 8'h25, 4'h0, d[3:0]});
    end
    // A short frame must leave the switches alone, and its flag must stick.
    send({8'h01, ~d}, 1 + $unsigned($random(seed)) % 15);
    exp_st[6] = 1'h1;
    chk_st();
    send({8'h01, d}, 16);
    chk_st();
    send(16'h6CA9, 16);
    exp_st[7:5] = 3'h0;
    chk_st();
    d = $random(seed);
    send({8'h01, d}, 20);
    exp_st[11:8] = d[3:0];
    exp_st[6] = 1'h1;
    chk_st();
    for (int k = 0; k < 3; k++)
    begin
      send(16'h6CA9, 16);
      send({bad[k], 8'h03}, 16);
      exp_st[7:5] = 3'h4;
      chk_st();
    end
    send(16'h6CA9, 16);
    send(16'h0202, 16);
    send(16'h7F0F, 16);
    exp_st[7:2] = 6'h02;
    chk_st();
    // CRC on; the clear flushes any flag left by the mode change.
    send(16'h0207, 16);
    send(16'h6CA9, 24);
    exp_st[7:2] = 6'h07;
    chk_st();
    d = $random(seed);
    send({8'h01, d}, 24);
    exp_st[11:8] = d[3:0];
    chk_rx({24'h0, 16'h2500, crc8(16'h2500)});
    chk_st();
    host.xfer(fr({8'h01, ~d}) ^ 48'h000001000000, 24, rx);
    exp_st[5] = 1'h1;
    chk_st();
    send({8'h01, ~d}, 16);
    exp_st[6] = 1'h1;
    chk_st();
    send(16'h8100, 24);
    chk_rx({24'h0, 8'h25, 4'h0, d[3:0], crc8({8'h25, 4'h0, d[3:0]})});
    host.xfer(fr(16'h6CA9) ^ 48'h000001000000, 24, rx);
    chk_st();
    send(16'h6CA9, 24);
    exp_st[7:5] = 3'h0;
    chk_st();
    // CRC off, burst on.
    send(16'h0206, 24);
    send(16'h0501, 16);
    send(16'h6CA9, 16);
    exp_st[4:1] = 4'hD;
    chk_st();
    d = $random(seed);
    host.xfer({8'h01, d, 16'h8100, 16'h0}, 32, rx);
    chk_rx({16'h0, 16'h2500, 8'h25, 4'h0, d[3:0]});
    exp_st[11:8] = d[3:0];
    chk_st();
    host.xfer({8'h01, d, 8'h01, ~d, 16'h0}, 40, rx);
    exp_st[11:8] = ~d[3:0];
    exp_st[6] = 1'h1;
    chk_st();
    // An interrupted key pair must not reset; a clean one must.
    send(16'h0BA3, 16);
    send(16'h8100, 16);
    send(16'h0B05, 16);
    chk_st();
    send(16'h0BA3, 16);
    send(16'h0B05, 16);
    exp_st = 12'h018;
    chk_st();
    repeat (12000) @(posedge mclk);
    send(16'h2500, 16);
    exp_st[0] = 1'h1;
    chk_rx(48'h2500);
    chk_st();
    last = 8'h00;
    for (int k = 0; k < 3; k++)
    begin
      b = (k == 0) ? 16'h0207 : 16'($random(seed));
      send(b, 16);
      chk_rx({32'h0, last, b[15:8]});
      exp_st[11:8] = b[3:0];
      chk_st();
      last = b[7:0];
    end
    hw_reset();
    finish_test();
  end
endmodule // sscd_top_bench
